// File: design/icdt_cfg.svh
`ifndef ICDT_CFG_SVH
`define ICDT_CFG_SVH
// Operation
// - Free-running counter wraps from all ones to zero.
// - Each qualifying event pushes the counter value; a full FIFO drops it.
// - Capture FIFO holds four values.
// - Sync mode captures freely; sync event clears counter.
// - Trigger mode holds counter until sync event.
// - Zero sync select, trigger bit clear: free-running.
// - Nonzero select: trigger bit picks trigger or sync.
// - Zero select, trigger bit set: software trigger starts.
// - Five-bit sync select, up to thirty sources.
// - Odd is low half; odd rollover increments even.
// - Cascade only when both channels set cascade bit.
// - Mode picks rising, falling, fourth, sixteenth or every edge.
// - Interrupt every event or every Nth event.
// - Time base select picks one of six clocks.
// - Not-empty flag set while FIFO holds data.
// - Each read of a non-empty buffer pops one value.
// - Cascaded even with trigger clear follows odd channel.
// - Odd channel settings govern the cascaded pair while the even trigger bit is clear.
// - Cascaded sync pair held reset until source enabled.

// ----------------------------------------
// Sizes
// ----------------------------------------
`define ICDT_CNT_W       16
`define ICDT_CNT_MAX     16'hffff
`define ICDT_FIFO_DEPTH  4
`define ICDT_SYNC_N      30
`define ICDT_TB_N        5

// ----------------------------------------
// Capture mode codes
// ----------------------------------------
`define ICDT_CM_OFF      3'h0
`define ICDT_CM_EDGE     3'h1
`define ICDT_CM_FALL     3'h2
`define ICDT_CM_RISE     3'h3
`define ICDT_CM_DIV4     3'h4
`define ICDT_CM_DIV16    3'h5
`define ICDT_CM_RSVD     3'h6
`define ICDT_CM_INTONLY  3'h7

// ----------------------------------------
// Selections and prescale ends
// ----------------------------------------
`define ICDT_TB_SYSCLK   3'h7
`define ICDT_TB_LASTTMR  3'h4
`define ICDT_SYNC_NONE   5'h00
`define ICDT_SYNC_LAST   5'h1e
`define ICDT_DIV4_LAST   4'h3
`define ICDT_DIV16_LAST  4'hf
`endif

// File: design/icdt_pkg.sv
package icdt_pkg;

	typedef enum logic [2:0] {
		ICDT_HALT = 3'b001,
		ICDT_WAIT = 3'b010,
		ICDT_RUN  = 3'b100
	} icdt_state_t;

endpackage

// File: design/icdt_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module icdt_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	input  wire logic             clk,
	input  wire logic             rstSync_b,
	input  wire logic             pushValid,
	output logic                  pushReady,
	input  wire logic [WIDTH-1:0] pushData,
	output logic                  popValid,
	input  wire logic             popReady,
	output logic      [WIDTH-1:0] popData
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wrPtr;
	logic [PW-1:0]    rdPtr;
	logic [CW-1:0]    count;
	logic             doPush;
	logic             doPop;

	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		if (p == PW'(DEPTH - 1))
			return '0;
		return p + PW'(1);
	endfunction

	assign pushReady = (count != CW'(DEPTH));
	assign popValid  = (count != '0);
	assign doPush    = pushValid & pushReady;
	assign doPop     = popValid & popReady;
	assign popData   = mem[rdPtr];

	always_ff @(posedge clk) begin
		if (doPush)
			mem[wrPtr] <= pushData;
	end

	always_ff @(posedge clk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else begin
			if (doPush)
				wrPtr <= bump(wrPtr);
			if (doPop)
				rdPtr <= bump(rdPtr);
			if (doPush && !doPop)
				count <= count + CW'(1);
			else if (doPop && !doPush)
				count <= count - CW'(1);
		end
	end
endmodule
`default_nettype wire

// File: design/icdt_capture.sv
`timescale 1ns/1ps
`default_nettype none
`include "icdt_cfg.svh"
module icdt_capture import icdt_pkg::*; #(
	parameter bit IS_EVEN    = 1'b0,
	parameter int CNT_W      = `ICDT_CNT_W,
	parameter int FIFO_DEPTH = `ICDT_FIFO_DEPTH,
	parameter int SYNC_N     = `ICDT_SYNC_N
) (
	input  wire logic              clk,
	input  wire logic              rst_b,
	input  wire logic              captureInput,
	input  wire logic [2:0]        captureModeSelect,
	input  wire logic [1:0]        capturesPerInterrupt,
	input  wire logic [2:0]        timebaseSelect,
	input  wire logic [4:0]        syncSourceSelect,
	input  wire logic              triggerModeSelect,
	input  wire logic              triggerStatusSet,
	input  wire logic              triggerStatusClear,
	input  wire logic              cascadeEnable,
	input  wire logic              syncSourceEnabled,
	input  wire logic [4:0]        timebaseTicks,
	input  wire logic [SYNC_N-1:0] syncEvents,
	input  wire logic              captureFifoReadStrobe,
	input  wire logic              overflowClear,
	input  wire logic              pairCascadeEnable,
	input  wire logic              pairRollover,
	input  wire logic              pairCapture,
	input  wire logic              pairRun,
	input  wire logic              pairCounterClear,
	output logic      [CNT_W-1:0]  captureFifoRead,
	output logic      [CNT_W-1:0]  captureCounter,
	output logic                   fifoNotEmpty,
	output logic                   overflowFlag,
	output logic                   triggerStatus,
	output logic                   captureInterrupt,
	output logic                   rolloverOut,
	output logic                   captureOut,
	output logic                   runOut,
	output logic                   counterClearOut
);
	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic rstMeta_b;
	logic rstSync_b;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rstMeta_b <= 1'b0;
			rstSync_b <= 1'b0;
		end else begin
			rstMeta_b <= 1'b1;
			rstSync_b <= rstMeta_b;
		end
	end

	// ----------------------------------------
	// Selection helpers
	// ----------------------------------------
	function automatic logic pickTick(input logic [2:0] sel, input logic [4:0] ticks);
		if (sel == `ICDT_TB_SYSCLK)
			return 1'b1;
		if (sel <= `ICDT_TB_LASTTMR)
			return ticks[sel];
		// Reserved codes give no clock
		return 1'b0;
	endfunction

	function automatic logic pickSync(input logic [4:0] sel, input logic [SYNC_N-1:0] ev);
		if (sel == `ICDT_SYNC_NONE || sel > `ICDT_SYNC_LAST)
			return 1'b0;
		return ev[sel - 5'h01];
	endfunction

	// ----------------------------------------
	// Capture mode helpers
	// ----------------------------------------
	// Reserved code leaves the channel idle, like off
	function automatic logic modeOn(input logic [2:0] mode);
		return (mode != `ICDT_CM_OFF) && (mode != `ICDT_CM_RSVD);
	endfunction

	function automatic logic isPrescaled(input logic [2:0] mode);
		return (mode == `ICDT_CM_DIV4) || (mode == `ICDT_CM_DIV16);
	endfunction

	function automatic logic [3:0] prescaleEnd(input logic [2:0] mode);
		if (mode == `ICDT_CM_DIV4)
			return `ICDT_DIV4_LAST;
		return `ICDT_DIV16_LAST;
	endfunction

	// ----------------------------------------
	// Mode decode
	// ----------------------------------------
	logic cascaded;
	logic evenCascaded;
	logic slave;
	logic selZero;
	logic freeMode;
	logic syncMode;
	logic trigMode;
	logic softTrig;
	logic waitsTrigger;
	logic syncPulse;
	logic ownTick;
	logic tick;
	logic enabled;
	logic holdReset;

	assign cascaded     = cascadeEnable & pairCascadeEnable;
	assign evenCascaded = IS_EVEN & cascaded;
	assign slave        = evenCascaded & ~triggerModeSelect;
	assign selZero      = (syncSourceSelect == `ICDT_SYNC_NONE);
	assign freeMode     = selZero & ~triggerModeSelect;
	assign syncMode     = ~selZero & ~triggerModeSelect;
	assign trigMode     = ~selZero & triggerModeSelect;
	assign softTrig     = selZero & triggerModeSelect;
	assign waitsTrigger = trigMode | softTrig;
	assign syncPulse    = pickSync(syncSourceSelect, syncEvents);
	assign ownTick      = pickTick(timebaseSelect, timebaseTicks);
	assign tick         = evenCascaded ? pairRollover : ownTick;
	assign enabled      = modeOn(captureModeSelect);
	// Pair waits in reset until its sync source is live
	assign holdReset    = cascaded & syncMode & ~syncSourceEnabled;

	// ----------------------------------------
	// Trigger status
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstSync_b) begin
		if (!rstSync_b)
			triggerStatus <= 1'b0;
		else if ((trigMode && syncPulse) || triggerStatusSet)
			triggerStatus <= 1'b1;
		else if (triggerStatusClear)
			triggerStatus <= 1'b0;
	end

	// ----------------------------------------
	// Run control
	// ----------------------------------------
	icdt_state_t state;
	icdt_state_t next_state;

	always_comb begin
		next_state = state;
		if (!enabled || holdReset) begin
			next_state = ICDT_HALT;
		end else if (slave) begin
			next_state = pairRun ? ICDT_RUN : ICDT_HALT;
		end else begin
			case (state)
				ICDT_HALT: begin
					next_state = waitsTrigger ? ICDT_WAIT : ICDT_RUN;
				end
				ICDT_WAIT: begin
					if (!waitsTrigger || triggerStatus)
						next_state = ICDT_RUN;
				end
				ICDT_RUN: begin
					if (waitsTrigger && !triggerStatus)
						next_state = ICDT_WAIT;
				end
				default: begin
					next_state = ICDT_HALT;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstSync_b) begin
		if (!rstSync_b)
			state <= ICDT_HALT;
		else
			state <= next_state;
	end

	logic running;
	logic syncReset;

	assign running   = (state == ICDT_RUN);
	// Sync reset of the even half comes from the odd half
	assign syncReset = (syncMode & syncPulse & ~slave) | (slave & pairCounterClear);

	// ----------------------------------------
	// Counter
	// ----------------------------------------
	logic wrapNow;

	assign wrapNow = running & tick & ~syncReset & (captureCounter == `ICDT_CNT_MAX);

	always_ff @(posedge clk or negedge rstSync_b) begin
		if (!rstSync_b)
			captureCounter <= '0;
		else if (state == ICDT_HALT || syncReset)
			captureCounter <= '0;
		else if (running && tick)
			captureCounter <= captureCounter + CNT_W'(1);
	end

	// ----------------------------------------
	// Capture pin and edge qualification
	// ----------------------------------------
	logic       capMeta;
	logic       capSync;
	logic       capPrev;
	logic       riseEdge;
	logic       fallEdge;
	logic [3:0] prescale;
	logic       ownEvent;
	logic       captureEvent;

	always_ff @(posedge clk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			capMeta <= 1'b0;
			capSync <= 1'b0;
		end else begin
			capMeta <= captureInput;
			capSync <= capMeta;
		end
	end

	// ----------------------------------------
	// Edge history
	// ----------------------------------------
	// Reset level matches the idle pin, so no false edge
	always_ff @(posedge clk or negedge rstSync_b) begin
		if (!rstSync_b)
			capPrev <= 1'b0;
		else
			capPrev <= capSync;
	end

	assign riseEdge = capSync & ~capPrev;
	assign fallEdge = ~capSync & capPrev;

	// Prescaler restarts whenever the channel is not running
	always_ff @(posedge clk or negedge rstSync_b) begin
		if (!rstSync_b)
			prescale <= '0;
		else if (!running)
			prescale <= '0;
		else if (riseEdge && isPrescaled(captureModeSelect))
			prescale <= (prescale == prescaleEnd(captureModeSelect)) ? 4'h0 : prescale + 4'h1;
	end

	always_comb begin
		case (captureModeSelect)
			`ICDT_CM_EDGE:    ownEvent = riseEdge | fallEdge;
			`ICDT_CM_FALL:    ownEvent = fallEdge;
			`ICDT_CM_RISE:    ownEvent = riseEdge;
			`ICDT_CM_DIV4:    ownEvent = riseEdge & (prescale == prescaleEnd(captureModeSelect));
			`ICDT_CM_DIV16:   ownEvent = riseEdge & (prescale == prescaleEnd(captureModeSelect));
			`ICDT_CM_INTONLY: ownEvent = riseEdge;
			default:          ownEvent = 1'b0;
		endcase
	end

	assign captureEvent = slave ? pairCapture : (running & ownEvent);

	// ----------------------------------------
	// Capture FIFO
	// ----------------------------------------
	logic             pushReady;
	logic             popValid;
	logic [CNT_W-1:0] popData;
	logic             doRead;

	icdt_fifo #(
		.WIDTH (CNT_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.rstSync_b (rstSync_b),
		.pushValid (captureEvent),
		.pushReady (pushReady),
		.pushData  (captureCounter),
		.popValid  (popValid),
		.popReady  (captureFifoReadStrobe),
		.popData   (popData)
	);

	assign doRead       = captureFifoReadStrobe & popValid;
	assign fifoNotEmpty = popValid;

	always_ff @(posedge clk or negedge rstSync_b) begin
		if (!rstSync_b)
			captureFifoRead <= '0;
		else if (doRead)
			captureFifoRead <= popData;
	end

	// A full FIFO keeps its oldest data; the newest is lost
	always_ff @(posedge clk or negedge rstSync_b) begin
		if (!rstSync_b)
			overflowFlag <= 1'b0;
		else if (captureEvent && !pushReady)
			overflowFlag <= 1'b1;
		else if (overflowClear)
			overflowFlag <= 1'b0;
	end

	// ----------------------------------------
	// Interrupt pacing
	// ----------------------------------------
	logic [1:0] eventCount;
	logic       intNow;

	// Every-edge mode ignores the pacing field
	assign intNow = captureEvent &
		((captureModeSelect == `ICDT_CM_EDGE) || (eventCount == capturesPerInterrupt));

	always_ff @(posedge clk or negedge rstSync_b) begin
		if (!rstSync_b)
			eventCount <= '0;
		else if (state == ICDT_HALT || intNow)
			eventCount <= '0;
		else if (captureEvent)
			eventCount <= eventCount + 2'h1;
	end

	always_ff @(posedge clk or negedge rstSync_b) begin
		if (!rstSync_b)
			captureInterrupt <= 1'b0;
		else
			captureInterrupt <= intNow;
	end

	// ----------------------------------------
	// Pair links
	// ----------------------------------------
	assign rolloverOut     = wrapNow;
	assign captureOut      = captureEvent;
	assign runOut          = running;
	assign counterClearOut = syncReset | (state == ICDT_HALT);

endmodule
`default_nettype wire

// File: testbench/icdt_capture_sva.sv
`timescale 1ns/1ps
`default_nettype none
module icdt_capture_sva #(
	parameter int FIFO_DEPTH = 4
) (
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic [2:0]  timebaseSelect,
	input wire logic [4:0]  syncSourceSelect,
	input wire logic        triggerModeSelect,
	input wire logic        triggerStatusSet,
	input wire logic [29:0] syncEvents,
	input wire logic        captureFifoReadStrobe,
	input wire logic [15:0] captureFifoRead,
	input wire logic [15:0] captureCounter,
	input wire logic        fifoNotEmpty,
	input wire logic        overflowFlag,
	input wire logic        triggerStatus,
	input wire logic        rolloverOut,
	input wire logic        captureOut,
	input wire logic        runOut,
	input wire logic        counterClearOut
);
	// --------
	// Fill mirror
	// --------
	logic [2:0] occ;

	// Dropped events never add, so a full buffer stays at depth
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			occ <= 3'h0;
		end else begin
			occ <= occ + 3'(captureOut && occ < FIFO_DEPTH) - 3'(captureFifoReadStrobe && fifoNotEmpty);
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	AST_WRAP: assert property (rolloverOut |=> captureCounter == 16'h0000)
		else $error("no wrap");
	AST_FREE: assert property (
		timebaseSelect == 3'h7 && runOut && !counterClearOut |=> captureCounter == $past(captureCounter) + 16'h0001)
		else $error("missed count");
	AST_STOP: assert property (!runOut && !counterClearOut |=> $stable(captureCounter))
		else $error("count while stopped");
	AST_SYNC: assert property (
		syncSourceSelect != 5'h00 && syncSourceSelect != 5'h1f && !triggerModeSelect && runOut
		&& syncEvents[syncSourceSelect - 5'h01] |=> captureCounter == 16'h0000)
		else $error("no sync clear");
	AST_PUSH: assert property (captureOut |=> fifoNotEmpty)
		else $error("flag low after push");
	AST_FIRST: assert property (
		captureOut && !fifoNotEmpty ##1 captureFifoReadStrobe |=> captureFifoRead == $past(captureCounter, 2))
		else $error("wrong stamp");
	AST_OVF: assert property (captureOut && occ == 3'(FIFO_DEPTH) && !captureFifoReadStrobe |=> overflowFlag)
		else $error("no overflow");
	AST_EMPTY_RD: assert property (captureFifoReadStrobe && !fifoNotEmpty |=> $stable(captureFifoRead))
		else $error("empty read moved data");
	AST_SOFT: assert property (syncSourceSelect == 5'h00 && triggerModeSelect && triggerStatusSet |=> triggerStatus)
		else $error("no soft trigger");
endmodule
bind icdt_capture icdt_capture_sva #(.FIFO_DEPTH(FIFO_DEPTH)) u_sva (.clk(clk), .rst_b(rst_b),
	.timebaseSelect(timebaseSelect), .syncSourceSelect(syncSourceSelect), .triggerModeSelect(triggerModeSelect),
	.triggerStatusSet(triggerStatusSet), .syncEvents(syncEvents), .captureFifoReadStrobe(captureFifoReadStrobe),
	.captureFifoRead(captureFifoRead), .captureCounter(captureCounter), .fifoNotEmpty(fifoNotEmpty),
	.overflowFlag(overflowFlag), .triggerStatus(triggerStatus), .rolloverOut(rolloverOut), .captureOut(captureOut),
	.runOut(runOut), .counterClearOut(counterClearOut));
`default_nettype wire

// File: testbench/icdt_pulse_src.sv
`timescale 1ns/1ps
`default_nettype none
module icdt_pulse_src (
	input  wire logic       pinLevel,
	input  wire logic       tickReq,
	input  wire logic [2:0] tickLine,
	input  wire logic       syncReq,
	input  wire logic [4:0] syncLine,
	output logic            captureInput,
	output logic [4:0]      timebaseTicks,
	output logic [29:0]     syncEvents
);
	// Pin moves off the clock grid, as an outside source would
	initial captureInput = 1'b0;
	always @(pinLevel) captureInput <= #7 pinLevel;
	assign timebaseTicks = tickReq ? 5'h01 << tickLine : 5'h00;
	assign syncEvents = syncReq ? 30'h1 << syncLine : 30'h0;
endmodule
`default_nettype wire

// File: testbench/input_capture_dedicated_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin comparisons++; if ((e) !== (a)) begin failures++; $display("Error %s expected %0h seen %0h", n, e, a); end end
module input_capture_dedicated_timer_tb;
	logic        clk = 0, rst_b = 0, pinLevel = 0, tickReq = 0, syncReq = 0, syncEn = 0, casc = 0, captureInput;
	logic        trig = 0, tsSet = 0, tsClr = 0, rdStb = 0, ovfClr = 0, fifoNotEmpty, overflowFlag, triggerStatus;
	logic        captureInterrupt, pairCasc = 0;
	logic [2:0]  mode = '0, tbSel = '0, tickLine = '0;
	logic [1:0]  cpi = '0;
	logic [4:0]  sync_source_select = '0, syncLine = '0, timebaseTicks;
	logic [29:0] syncEvents;
	logic [15:0] captureFifoRead, captureCounter;
	logic [7:0]  rnd = 8'h04;
	int          failures = 0, comparisons = 0, cnt = 0, pre = 0, icnt = 0, eInts = 0, sInts = 0, exp = 0;
	bit          run = 0, ovf = 0;
	int          q[$];
	logic [2:0]  mTab[10] = '{3'h3, 3'h3, 3'h3, 3'h3, 3'h1, 3'h4, 3'h5, 3'h2, 3'h7, 3'h6};
	int          nTab[10] = '{3, 4, 4, 4, 2, 8, 16, 3, 3, 2};

	icdt_capture u_dut (.clk(clk), .rst_b(rst_b), .captureInput(captureInput), .captureModeSelect(mode),
		.capturesPerInterrupt(cpi), .timebaseSelect(tbSel), .syncSourceSelect(sync_source_select), .triggerModeSelect(trig),
		.triggerStatusSet(tsSet), .triggerStatusClear(tsClr), .cascadeEnable(casc), .syncSourceEnabled(syncEn),
		.timebaseTicks(timebaseTicks), .syncEvents(syncEvents), .captureFifoReadStrobe(rdStb),
		.overflowClear(ovfClr), .pairCascadeEnable(pairCasc), .pairRollover(1'b0), .pairCapture(1'b0),
		.pairRun(1'b0), .pairCounterClear(1'b0), .captureFifoRead(captureFifoRead),
		.captureCounter(captureCounter), .fifoNotEmpty(fifoNotEmpty), .overflowFlag(overflowFlag),
		.triggerStatus(triggerStatus), .captureInterrupt(captureInterrupt), .rolloverOut(), .captureOut(),
		.runOut(), .counterClearOut());
	icdt_pulse_src u_src (.pinLevel(pinLevel), .tickReq(tickReq), .tickLine(tickLine), .syncReq(syncReq),
		.syncLine(syncLine), .captureInput(captureInput), .timebaseTicks(timebaseTicks), .syncEvents(syncEvents));

	always #10 clk = ~clk;
	always @(posedge clk) if (captureInterrupt === 1'b1) sInts++;

	// --------
	// Drivers and model
	// --------
	function automatic logic [7:0] lfsr(logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic step(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic ticks(int n, int line = 0);
		tickLine = 3'(line);
		tickReq = 1;
		step(n);
		tickReq = 0;
		step(1);
		if (run && line == tbSel) cnt = (cnt + n) % 65536;
	endtask
	task automatic pin(logic v);
		pinLevel = v;
		step(8);
		if (mode == 3'h1 || mode == (v ? 3'h3 : 3'h2) || (v && (mode == 3'h4 || mode == 3'h5 || mode == 3'h7))) begin
			pre++;
			if (mode != 3'h4 && mode != 3'h5 || pre == (mode == 3'h4 ? 4 : 16)) begin
				pre = 0;
				if (q.size() < 4) q.push_back(cnt); else ovf = 1;
				icnt++;
				if (mode == 3'h1 || icnt == cpi + 1) begin
					icnt = 0;
					eInts++;
				end
			end
		end
	endtask
	task automatic pop();
		exp = q.pop_front();
		rdStb = 1;
		step(1);
		rdStb = 0;
		step(1);
		`CHK("fifo data", exp, captureFifoRead)
		`CHK("not empty", q.size() != 0, fifoNotEmpty)
	endtask
	task automatic sync(int i);
		syncLine = 5'(i);
		syncReq = 1;
		step(1);
		syncReq = 0;
		step(2);
		if (i == sync_source_select - 1) begin
			if (trig) run = 1; else cnt = 0;
		end
	endtask
	task automatic cfg(logic [4:0] sel, logic tr, logic [2:0] md);
		mode = 3'h0;
		step(3);
		cnt = 0;
		pre = 0;
		icnt = 0;
		sync_source_select = sel;
		trig = tr;
		tsClr = tr;
		step(1);
		tsClr = 0;
		mode = md;
		step(3);
		run = !tr;
	endtask
	task automatic done(string s);
		$display("test %s done", s);
	endtask
	task automatic end_of_test();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Longest test is the full wrap, about 66k cycles
	initial begin
		repeat (90000) @(posedge clk);
		failures++;
		end_of_test();
	end

	// --------
	// Tests
	// --------
	initial begin
		repeat (8) @(posedge clk);
		#1 rst_b = 1;
		step(4);
		casc = 1;
		cfg(5'h00, 1'b0, 3'h3);
		ticks(5);
		`CHK("counter", cnt, captureCounter)
		repeat (5) begin
			rnd = lfsr(rnd);
			ticks(1 + rnd % 7);
			pin(1);
			pin(0);
		end
		`CHK("overflow", ovf, overflowFlag)
		while (q.size() > 0) pop();
		rdStb = 1;
		step(1);
		rdStb = 0;
		step(1);
		`CHK("empty read", exp, captureFifoRead)
		ovfClr = 1;
		step(1);
		ovfClr = 0;
		step(1);
		`CHK("overflow clear", 1'b0, overflowFlag)
		pinLevel = 1;
		while (!fifoNotEmpty) step(1);
		rdStb = 1;
		step(1);
		rdStb = 0;
		pinLevel = 0;
		step(8);
		`CHK("early read", cnt, captureFifoRead)
		`CHK("early empty", 1'b0, fifoNotEmpty)
		casc = 0;
		done("fifo");
		for (int i = 0; i < 10; i++) begin
			cpi = 2'(i + 1);
			cfg(5'h00, 1'b0, mTab[i]);
			eInts = 0;
			sInts = 0;
			repeat (nTab[i]) begin
				ticks(1);
				pin(1);
				ticks(1);
				pin(0);
			end
			`CHK("interrupts", eInts, sInts)
			while (q.size() > 0) pop();
		end
		done("modes");
		cfg(5'h00, 1'b0, 3'h3);
		for (int l = 0; l < 5; l++) begin
			tbSel = 3'(l);
			step(1);
			ticks(3, l);
			ticks(2, (l + 1) % 5);
			`CHK("time base", cnt, captureCounter)
		end
		tbSel = 3'h7;
		step(5);
		cnt = (cnt + 5) % 65536;
		`CHK("system clock", cnt, captureCounter)
		tbSel = 3'h0;
		done("timebase");
		cfg(5'h03, 1'b0, 3'h3);
		pairCasc = 1;
		step(1);
		casc = 1;
		run = 0;
		ticks(4);
		`CHK("sync hold", cnt, captureCounter)
		pairCasc = 0;
		step(2);
		run = 1;
		syncEn = 1;
		ticks(10);
		`CHK("one-sided cascade", cnt, captureCounter)
		sync(4);
		`CHK("other sync", cnt, captureCounter)
		sync(2);
		`CHK("sync clear", cnt, captureCounter)
		ticks(3);
		pin(1);
		pin(0);
		pop();
		casc = 0;
		done("sync");
		cfg(5'h03, 1'b1, 3'h3);
		ticks(4);
		`CHK("trigger hold", cnt, captureCounter)
		sync(2);
		`CHK("trigger status", 1'b1, triggerStatus)
		ticks(6);
		`CHK("trigger run", cnt, captureCounter)
		tsClr = 1;
		step(1);
		tsClr = 0;
		step(2);
		run = 0;
		ticks(3);
		`CHK("rearm hold", cnt, captureCounter)
		done("trigger");
		cfg(5'h00, 1'b1, 3'h3);
		ticks(4);
		`CHK("soft hold", cnt, captureCounter)
		tsSet = 1;
		step(1);
		tsSet = 0;
		step(2);
		run = 1;
		ticks(5);
		`CHK("soft run", cnt, captureCounter)
		done("soft");
		cfg(5'h00, 1'b0, 3'h3);
		ticks(65535);
		`CHK("top", cnt, captureCounter)
		ticks(2);
		`CHK("wrap", cnt, captureCounter)
		done("wrap");
		end_of_test();
	end
endmodule
`default_nettype wire
